// ### design/hpp_host_port.sv
// Parallel host port: host access to memory, address pointer and control.
// Assumes host pins are synchronous to clk_sys_i and memory answers reads.
//
// Function
// (R1) Byte enables apply to memory, pointer, control
// (R2) Single-byte write keeps the other byte
// (R3) Single-byte read drives only enabled lane
// (R4) Host without byte enables holds them low
// (R5) Reset mode is memory interface or multiplexed
// (R6) Selection code 10b gives nonmultiplexed mode
// (R7) Nonmultiplexed uses address bus, pointer unused
// (R8) Holding register keeps read or write word
// (R9) Control holds irq bit, host-only access
// (R10) Nonmux select low control, high data
// (R11) Nonmux allows control and plain data only
// (R12) Host drives direction high read, low write
// (R13) Nonmux captures select/direction at strobe fall
// (R14) Mux mode by strap low or 11b
// (R15) Host loads pointer before mux data access
// (R16) Host writes pointer with zero top bits
// (R17) Mux select decode: control, inc, pointer, data
// (R18) Address strobe latches select and direction
// (R19) Mux samples at address or internal strobe
// (R20) Unused address strobe held high by host
// (R21) Mux mode ignores the address bus
// (R22) Byte enable code 11 touches nothing; data reads still reach memory, pointer writes reload the internal address
`timescale 1ns/1ps
module hpp_host_port
    import hpp_pkg::*;
#(
    parameter int AW = HPP_AW,
    parameter int DW = HPP_DW
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic boot_port_mode_pin_i,
    input wire logic bsel_wr_i,
    input wire logic [1:0] bsel_wdata_i,
    output logic [1:0] bus_sel_o,
    input wire logic internal_combined_strobe_n_i,
    input wire logic host_addr_strobe_n_i,
    input wire logic access_select_low_i,
    input wire logic access_select_high_i,
    input wire logic transfer_direction_i,
    input wire logic [1:0] byte_lane_enables_n_i,
    input wire logic [AW-1:0] host_address_bus_i,
    input wire logic [DW-1:0] host_data_bus_i,
    output logic [DW-1:0] host_data_bus_o,
    output logic [1:0] host_data_bus_oe_o,
    output logic host_ready_o,
    output logic host_to_processor_irq_o,
    output logic mem_rd_req_o,
    output logic [AW-1:0] mem_rd_addr_o,
    input wire logic mem_rd_valid_i,
    input wire logic [DW-1:0] mem_rd_data_i,
    output logic mem_wr_valid_o,
    input wire logic mem_wr_ready_i,
    output logic [AW-1:0] mem_wr_addr_o,
    output logic [DW-1:0] mem_wr_data_o,
    output logic [1:0] mem_wr_be_o
);

    localparam int FW = AW + DW + 2;
    localparam int LW = DW / 2;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    hpp_state_t state_q;
    logic [1:0] mode_q;
    logic strb_q, has_q, has_seen_q;
    logic [1:0] lat_sel_q, lat_be_n_q;
    logic lat_rd_q;
    logic [1:0] cyc_sel_q, cyc_be_n_q;
    logic cyc_rd_q;
    logic [AW-1:0] cyc_addr_q, addr_q, wa_q;
    logic [DW-1:0] ptr_q, hold_q, ctrl_q, dout_q;
    logic [1:0] oe_q;
    logic rdy_q, irq_q, rd_req_q;
    logic [AW-1:0] rd_addr_q;
    logic [FW-1:0] out_q, sk_q;
    logic out_v_q, sk_v_q;
    logic port_on, is_mux, strb_fall, strb_rise, has_fall;
    logic [1:0] live_sel, cap_sel, cap_be_n;
    logic cap_rd, wr_end, push, in_ready;
    logic [DW-1:0] wmerge, rd_word;
    logic [1:0] lane_en;

    // Lane merge of new data into an old word
    function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_w,
                                            input logic [DW-1:0] new_w,
                                            input logic [1:0] be_n);
        logic [DW-1:0] r;
        r = old_w;
        for (int i = 0; i < 2; i++) begin
            if (!be_n[i]) begin
                r[i*LW +: LW] = new_w[i*LW +: LW];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Pin decode
    // ------------------------------------------------------------
    assign is_mux = (mode_q == HPP_MODE_MUX);
    assign port_on = is_mux || (mode_q == HPP_MODE_NONMUX);
    assign strb_fall = strb_q && !internal_combined_strobe_n_i;
    assign strb_rise = !strb_q && internal_combined_strobe_n_i;
    assign has_fall = has_q && !host_addr_strobe_n_i && is_mux;
    // (R10) (R11) nonmux select: control or plain data
    assign live_sel = is_mux ? {access_select_high_i, access_select_low_i}
                    : (access_select_low_i ? HPP_SEL_DATA : HPP_SEL_CTRL);
    // (R19) address strobe values win when latched
    assign cap_sel = (is_mux && has_seen_q) ? lat_sel_q : live_sel;
    assign cap_rd = (is_mux && has_seen_q) ? lat_rd_q : transfer_direction_i;
    assign cap_be_n = (is_mux && has_seen_q) ? lat_be_n_q : byte_lane_enables_n_i;
    assign wr_end = (state_q == HPP_ST_ACT) && strb_rise && !cyc_rd_q;
    // (R1) one merge serves memory, pointer and control
    assign wmerge = merge((cyc_sel_q == HPP_SEL_PTR) ? ptr_q
                          : (cyc_sel_q == HPP_SEL_CTRL) ? ctrl_q : hold_q,
                          host_data_bus_i, cyc_be_n_q);
    assign in_ready = !sk_v_q;
    assign push = (state_q == HPP_ST_WR) && in_ready;
    // (R3) (R22) lanes driven only when enabled
    assign lane_en = ~cyc_be_n_q;
    always_comb begin
        rd_word = hold_q;
        if (cyc_sel_q == HPP_SEL_CTRL) begin
            rd_word = ctrl_q;
            rd_word[HPP_CTRL_IRQ_BIT] = 1'b0;
        end else if (cyc_sel_q == HPP_SEL_PTR) begin
            rd_word = ptr_q;
        end
    end

    // ------------------------------------------------------------
    // Port mode
    // ------------------------------------------------------------
    // (R5) (R14) strap low gives mux, else memory interface
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            mode_q <= boot_port_mode_pin_i ? HPP_MODE_EXTMEM : HPP_MODE_MUX;
        end else if (bsel_wr_i) begin
            // (R6) (R14) software selects the port mode
            mode_q <= bsel_wdata_i;
        end
    end

    // ------------------------------------------------------------
    // Strobe edges and address strobe latch
    // ------------------------------------------------------------
    // (R18) (R20) latch cycle type on address strobe fall
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            strb_q <= 1'b1;
            has_q <= 1'b1;
            has_seen_q <= 1'b0;
            lat_sel_q <= HPP_SEL_CTRL;
            lat_rd_q <= 1'b0;
            lat_be_n_q <= HPP_BE_N_NONE;
        end else begin
            strb_q <= internal_combined_strobe_n_i;
            has_q <= host_addr_strobe_n_i;
            if (has_fall) begin
                has_seen_q <= 1'b1;
                lat_sel_q <= {access_select_high_i, access_select_low_i};
                lat_rd_q <= transfer_direction_i;
                lat_be_n_q <= byte_lane_enables_n_i;
            end else if (strb_rise) begin
                has_seen_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Cycle capture at internal strobe fall
    // ------------------------------------------------------------
    // (R13) (R19) select and direction taken at strobe fall
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            cyc_sel_q <= HPP_SEL_CTRL;
            cyc_rd_q <= 1'b0;
            cyc_be_n_q <= HPP_BE_N_NONE;
            cyc_addr_q <= '0;
        end else if (state_q == HPP_ST_IDLE && strb_fall && port_on) begin
            cyc_sel_q <= cap_sel;
            cyc_rd_q <= cap_rd;
            cyc_be_n_q <= cap_be_n;
            // (R7) (R21) address bus only in nonmux mode
            cyc_addr_q <= is_mux ? addr_q : host_address_bus_i;
        end
    end

    // ------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state_q <= HPP_ST_IDLE;
            rd_req_q <= 1'b0;
            rd_addr_q <= '0;
        end else begin
            rd_req_q <= 1'b0;
            case (state_q)
                HPP_ST_IDLE: begin
                    if (strb_fall && port_on) begin
                        if (cap_rd && cap_sel[0]) begin
                            rd_req_q <= 1'b1;
                            rd_addr_q <= is_mux ? addr_q : host_address_bus_i;
                            state_q <= HPP_ST_RD;
                        end else begin
                            state_q <= HPP_ST_ACT;
                        end
                    end
                end
                HPP_ST_RD: begin
                    if (mem_rd_valid_i) begin
                        state_q <= HPP_ST_ACT;
                    end
                end
                HPP_ST_ACT: begin
                    if (strb_rise) begin
                        // (R22) no lanes means no memory write
                        if (!cyc_rd_q && cyc_sel_q[0] && cyc_be_n_q != HPP_BE_N_NONE) begin
                            state_q <= HPP_ST_WR;
                        end else begin
                            state_q <= HPP_ST_IDLE;
                        end
                    end
                end
                HPP_ST_WR: begin
                    if (in_ready) begin
                        state_q <= HPP_ST_IDLE;
                    end
                end
                default: state_q <= HPP_ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Holding register
    // ------------------------------------------------------------
    // (R8) word read from memory or word to be written
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            hold_q <= HPP_HOLD_RST;
            wa_q <= '0;
        end else if (state_q == HPP_ST_RD && mem_rd_valid_i) begin
            hold_q <= mem_rd_data_i;
        end else if (wr_end && cyc_sel_q[0]) begin
            // (R2) only enabled lanes change
            hold_q <= wmerge;
            wa_q <= cyc_addr_q;
        end
    end

    // ------------------------------------------------------------
    // Address pointer and internal address
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            ptr_q <= HPP_PTR_RST;
            addr_q <= '0;
        end else if (wr_end && cyc_sel_q == HPP_SEL_PTR && is_mux) begin
            // (R15) (R16) pointer loaded by host write
            ptr_q <= wmerge;
            addr_q <= wmerge[AW-1:0];
        end else if (state_q == HPP_ST_ACT && strb_rise && is_mux
                     && cyc_sel_q == HPP_SEL_DATA_INC && !cyc_be_n_q[HPP_BE_HI]) begin
            // (R17) post-increment after upper lane access
            addr_q <= AW'(addr_q + 1'b1);
        end
    end

    // ------------------------------------------------------------
    // Control register and processor interrupt
    // ------------------------------------------------------------
    // (R9) irq bit pulses once per written one
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            ctrl_q <= HPP_CTRL_RST;
            irq_q <= 1'b0;
        end else begin
            irq_q <= 1'b0;
            if (wr_end && cyc_sel_q == HPP_SEL_CTRL) begin
                ctrl_q <= wmerge & ~(16'h0001 << HPP_CTRL_IRQ_BIT);
                irq_q <= wmerge[HPP_CTRL_IRQ_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // Host data drive and ready
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            dout_q <= '0;
            oe_q <= 2'h0;
            rdy_q <= 1'b1;
        end else begin
            dout_q <= rd_word;
            // (R3) disabled lane stays high impedance
            oe_q <= (state_q == HPP_ST_ACT && cyc_rd_q && !strb_rise) ? lane_en : 2'h0;
            if (state_q == HPP_ST_IDLE) begin
                rdy_q <= in_ready && !(strb_fall && port_on);
            end else begin
                rdy_q <= (state_q == HPP_ST_ACT);
            end
        end
    end

    // ------------------------------------------------------------
    // Two-entry write buffer toward memory
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            out_v_q <= 1'b0;
            sk_v_q <= 1'b0;
            out_q <= '0;
            sk_q <= '0;
        end else if (!out_v_q || mem_wr_ready_i) begin
            if (sk_v_q) begin
                out_q <= sk_q;
                out_v_q <= 1'b1;
                sk_v_q <= 1'b0;
            end else begin
                out_q <= {wa_q, hold_q, lane_en};
                out_v_q <= push;
            end
        end else if (push) begin
            sk_q <= {wa_q, hold_q, lane_en};
            sk_v_q <= 1'b1;
        end
    end

    // Outputs straight from flops
    assign bus_sel_o = mode_q;
    assign host_data_bus_o = dout_q;
    assign host_data_bus_oe_o = oe_q;
    assign host_ready_o = rdy_q;
    assign host_to_processor_irq_o = irq_q;
    assign mem_rd_req_o = rd_req_q;
    assign mem_rd_addr_o = rd_addr_q;
    assign mem_wr_valid_o = out_v_q;
    assign mem_wr_addr_o = out_q[FW-1 -: AW];
    assign mem_wr_data_o = out_q[DW+1:2];
    assign mem_wr_be_o = out_q[1:0];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    AST_BYTE_KEEP: assert property (wr_end && cyc_sel_q == HPP_SEL_PTR && is_mux // R2
        && cyc_be_n_q[0] |=> ptr_q[7:0] == $past(ptr_q[7:0]))
        else $error("pointer low byte changed on upper byte write");
    AST_LANE_HIZ: assert property (oe_q[0] |-> !cyc_be_n_q[0] && cyc_rd_q) // R3
        else $error("lower lane driven while disabled");
    AST_NONE_LANES: assert property (cyc_be_n_q == HPP_BE_N_NONE |-> oe_q == 2'h0 // R22
        && state_q != HPP_ST_WR)
        else $error("disabled code touched lanes or memory");
    AST_RESET_MODE: assert property ($past(srst_i) |-> mode_q != HPP_MODE_NONMUX) // R5
        else $error("nonmultiplexed mode right after reset");
    AST_NONMUX_SEL: assert property (bsel_wr_i && bsel_wdata_i == HPP_MODE_NONMUX // R6
        |=> mode_q == HPP_MODE_NONMUX)
        else $error("selection code 10b ignored");
    AST_NONMUX_ADDR: assert property (state_q == HPP_ST_IDLE && strb_fall // R7
        && mode_q == HPP_MODE_NONMUX && cap_rd && access_select_low_i
        |=> mem_rd_req_o && mem_rd_addr_o == $past(host_address_bus_i))
        else $error("nonmux read used wrong address");
    AST_IRQ_PULSE: assert property (host_to_processor_irq_o |=> !host_to_processor_irq_o // R9
        && !ctrl_q[HPP_CTRL_IRQ_BIT])
        else $error("irq bit not a single pulse");
    AST_CTRL_SEL: assert property (state_q == HPP_ST_IDLE && strb_fall // R10
        && mode_q == HPP_MODE_NONMUX && !access_select_low_i |=> cyc_sel_q == HPP_SEL_CTRL)
        else $error("nonmux low select not control");
    AST_INC: assert property (state_q == HPP_ST_ACT && strb_rise && is_mux // R17
        && cyc_sel_q == HPP_SEL_DATA_INC && !cyc_be_n_q[1] && !wr_end
        |=> addr_q == $past(addr_q) + 1'b1)
        else $error("auto increment missed");
    AST_HAS_LATCH: assert property (has_fall |=> has_seen_q // R18
        && lat_sel_q == $past({access_select_high_i, access_select_low_i}))
        else $error("address strobe did not latch select");
    AST_RD_DONE: assert property (state_q == HPP_ST_RD && mem_rd_valid_i // R8
        |=> state_q == HPP_ST_ACT && hold_q == $past(mem_rd_data_i))
        else $error("read word not held for data phase");

    COV_MUX_INC_RD: cover property (mem_rd_req_o ##[1:20] oe_q != 2'h0);
    COV_BUF_FULL: cover property (sk_v_q && out_v_q);
    COV_IRQ: cover property (host_to_processor_irq_o);
    COV_BYTE_RD: cover property (oe_q == 2'h2);

endmodule

// ### design/hpp_pkg.sv
// Constants, codes and state type for the parallel host port.
// Assumes one 40 MHz system clock and synchronous host pin levels.
package hpp_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int HPP_DW = 16;
    localparam int HPP_AW = 14;
    localparam int HPP_CLK_MHZ = 40;

    // ------------------------------------------------------------
    // Bus selection field codes, field at bits 1-0
    // ------------------------------------------------------------
    localparam int HPP_BSEL_LSB = 0;
    localparam logic [1:0] HPP_MODE_EXTMEM = 2'h0;
    localparam logic [1:0] HPP_MODE_NONMUX = 2'h2;
    localparam logic [1:0] HPP_MODE_MUX = 2'h3;

    // ------------------------------------------------------------
    // Access select codes {high, low}
    // ------------------------------------------------------------
    localparam logic [1:0] HPP_SEL_CTRL = 2'h0;
    localparam logic [1:0] HPP_SEL_DATA_INC = 2'h1;
    localparam logic [1:0] HPP_SEL_PTR = 2'h2;
    localparam logic [1:0] HPP_SEL_DATA = 2'h3;

    // ------------------------------------------------------------
    // Byte enable codes, active low, bit 1 is the upper lane
    // ------------------------------------------------------------
    localparam logic [1:0] HPP_BE_N_NONE = 2'h3;
    localparam int HPP_BE_HI = 1;

    // ------------------------------------------------------------
    // Control register layout and reset values
    // ------------------------------------------------------------
    localparam int HPP_CTRL_IRQ_BIT = 1;
    localparam logic [15:0] HPP_CTRL_RST = 16'h0000;
    localparam logic [15:0] HPP_PTR_RST = 16'h0000;
    localparam logic [15:0] HPP_HOLD_RST = 16'h0000;

    // ------------------------------------------------------------
    // Access sequencer states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        HPP_ST_IDLE = 4'h1,
        HPP_ST_RD = 4'h2,
        HPP_ST_ACT = 4'h4,
        HPP_ST_WR = 4'h8
    } hpp_state_t;

endpackage

// ### verification/hpp_mem_model.sv
// Memory-side partner: answers port reads and takes buffered writes.
// Assumes one clock; stall_i from the bench holds off write acceptance.
`timescale 1ns/1ps
module hpp_mem_model (
    input wire logic clk_i,
    input wire logic stall_i,
    input wire logic rd_req_i,
    input wire logic [13:0] rd_addr_i,
    output logic rd_valid_o,
    output logic [15:0] rd_data_o,
    input wire logic wr_valid_i,
    output logic wr_ready_o,
    input wire logic [13:0] wr_addr_i,
    input wire logic [15:0] wr_data_i,
    input wire logic [1:0] wr_be_i
);
    logic [15:0] mem [int];
    logic [15:0] cur;
    logic [13:0] addr_q = 14'h0000;
    int wait_n = -1;
    initial begin
        rd_valid_o = 1'b0;
        rd_data_o = 16'h0000;
        wr_ready_o = 1'b0;
    end
    // Reads answered after a random delay, junk on the data lines otherwise
    always @(posedge clk_i) begin
        rd_valid_o <= 1'b0;
        rd_data_o <= ~rd_data_o;
        if (rd_req_i) begin
            addr_q <= rd_addr_i;
            wait_n <= $urandom_range(3, 0);
        end else if (wait_n == 0) begin
            rd_valid_o <= 1'b1;
            rd_data_o <= mem.exists(addr_q) ? mem[addr_q] : {2'b00, addr_q} ^ 16'h5A5A;
            wait_n <= -1;
        end else if (wait_n > 0) begin
            wait_n <= wait_n - 1;
        end
    end
    // Writes accepted at random unless stalled, enabled lanes merged
    always @(posedge clk_i) begin
        wr_ready_o <= !stall_i && ($urandom_range(1, 0) == 1);
        if (wr_valid_i && wr_ready_o) begin
            cur = mem.exists(wr_addr_i) ? mem[wr_addr_i] : {2'b00, wr_addr_i} ^ 16'h5A5A;
            if (wr_be_i[1]) cur[15:8] = wr_data_i[15:8];
            if (wr_be_i[0]) cur[7:0] = wr_data_i[7:0];
            mem[wr_addr_i] = cur;
        end
    end
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the host port against a reference model.
// Assumes the memory partner model stands on the memory side.
`timescale 1ns/1ps
module tb_top;
    import hpp_pkg::*;
    logic clk_sys_i = 1'b0, srst_i = 1'b1, strap = 1'b1, bwr = 1'b0, stb_n = 1'b1;
    logic as_n = 1'b1, dir = 1'b0, stall = 1'b0;
    logic [1:0] bwd = 2'b00, sel = 2'b00, be_n = 2'b00, bus_sel, oe, wbe, md;
    logic [13:0] haddr = 14'h0000, rad, wad, ia_m, a;
    logic [15:0] hdat = 16'h0000, hdo, rdat, wdat, ctrl_m, ptr_m, w;
    logic rdy, irq, rreq, rval, wval, wrdy;
    logic [15:0] ref_mem [int];
    int fail_count = 0, total_checks = 0, irq_cnt = 0;

    always #12.5 clk_sys_i = ~clk_sys_i;
    // Count control interrupt pulses
    always @(posedge clk_sys_i) if (!srst_i && irq === 1'b1) irq_cnt++;

    hpp_host_port dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .boot_port_mode_pin_i(strap),
        .bsel_wr_i(bwr), .bsel_wdata_i(bwd), .bus_sel_o(bus_sel),
        .internal_combined_strobe_n_i(stb_n), .host_addr_strobe_n_i(as_n),
        .access_select_low_i(sel[0]), .access_select_high_i(sel[1]),
        .transfer_direction_i(dir), .byte_lane_enables_n_i(be_n), .host_address_bus_i(haddr),
        .host_data_bus_i(hdat), .host_data_bus_o(hdo), .host_data_bus_oe_o(oe),
        .host_ready_o(rdy), .host_to_processor_irq_o(irq), .mem_rd_req_o(rreq),
        .mem_rd_addr_o(rad), .mem_rd_valid_i(rval), .mem_rd_data_i(rdat),
        .mem_wr_valid_o(wval), .mem_wr_ready_i(wrdy), .mem_wr_addr_o(wad),
        .mem_wr_data_o(wdat), .mem_wr_be_o(wbe));
    hpp_mem_model u_mem (.clk_i(clk_sys_i), .stall_i(stall), .rd_req_i(rreq), .rd_addr_i(rad),
        .rd_valid_o(rval), .rd_data_o(rdat), .wr_valid_i(wval), .wr_ready_o(wrdy),
        .wr_addr_i(wad), .wr_data_i(wdat), .wr_be_i(wbe));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #2;
    endtask
    // Bounded wait for ready high
    task automatic wait_rdy();
        int n;
        n = 0;
        while (rdy !== 1'b1) begin
            tick(1);
            n++;
            if (n > 300) begin
                fail_count++;
                print_verdict();
            end
        end
    endtask
    task automatic do_reset(input logic pin);
        srst_i = 1'b1;
        strap = pin;
        tick(4);
        srst_i = 1'b0;
        ctrl_m = 16'h0000;
        ptr_m = 16'h0000;
        ia_m = 14'h0000;
        md = pin ? HPP_MODE_EXTMEM : HPP_MODE_MUX;
        tick(2);
        check("bus_sel", {14'h0000, bus_sel}, {14'h0000, md});
    endtask
    task automatic set_mode(input logic [1:0] v);
        bwr = 1'b1;
        bwd = v;
        tick(1);
        bwr = 1'b0;
        tick(1);
        md = v;
        check("bus_sel", {14'h0000, bus_sel}, {14'h0000, v});
    endtask
    // One host cycle, then the model decides the expected outcome
    task automatic acc(input logic [1:0] s, input logic d, input logic [1:0] b,
                       input logic [13:0] ad, input logic [15:0] wv, input logic use_as);
        logic [15:0] old, nv, mask, got;
        logic [1:0] goe;
        logic [13:0] ma;
        int k, n, irq0;
        mask = {{8{~b[1]}}, {8{~b[0]}}};
        k = (md == HPP_MODE_NONMUX) ? (s[0] ? 3 : 0) : int'(s);
        ma = (md == HPP_MODE_NONMUX) ? ad : ia_m;
        old = (k == 0) ? ctrl_m : (k == 2) ? ptr_m :
              (ref_mem.exists(ma) ? ref_mem[ma] : {2'b00, ma} ^ 16'h5A5A);
        irq0 = irq_cnt;
        n = 0;
        while (d && wval === 1'b1 && n < 300) begin
            tick(1);
            n++;
        end
        // Write buffer never drained
        if (n >= 300) begin
            fail_count++;
            print_verdict();
        end
        sel = s;
        // direction level, unused address strobe high
        dir = d;
        be_n = b;
        haddr = ad;
        hdat = wv;
        as_n = ~use_as;
        if (use_as) begin
            tick(1);
            sel = ~s;
            dir = ~d;
        end
        stb_n = 1'b0;
        tick(3);
        wait_rdy();
        got = hdo;
        goe = oe;
        stb_n = 1'b1;
        tick(2);
        wait_rdy();
        as_n = 1'b1;
        tick(1);
        if (d) begin
            check("oe_rd", {14'h0000, goe}, {14'h0000, ~b});
            check("rdata", got & mask, old & mask);
        end else begin
            check("oe_wr", {14'h0000, goe}, 16'h0000);
            nv = (wv & mask) | (old & ~mask);
            if (k == 0) ctrl_m = nv & ~16'h0002;
            else if (k == 2) begin
                ptr_m = nv;
                ia_m = nv[13:0];
            end else ref_mem[ma] = nv;
        end
        if (k == 1 && !b[1]) ia_m = ia_m + 14'h0001;
        check("irq", 16'(irq_cnt - irq0), (k == 0 && !d && !b[0] && wv[1]) ? 16'h0001 : 16'h0000);
    endtask

    initial begin
        void'($urandom(53));
        do_reset(1'b1);
        set_mode(HPP_MODE_MUX);
        set_mode(HPP_MODE_NONMUX);
        // Every byte code on control and memory, read back by lane and whole
        for (int b = 0; b < 4; b++) begin
            for (int t = 0; t < 2; t++) begin
                a = 14'($urandom);
                w = 16'($urandom);
                acc({w[15], t[0]}, 1'b0, b[1:0], a, w, 1'b0);
                acc({w[14], t[0]}, 1'b1, b[1:0], a, w, 1'b0);
                acc({w[13], t[0]}, 1'b1, 2'b00, a, w, 1'b0);
            end
        end
        // Stalled memory side fills the buffer, then drains with nothing lost
        stall = 1'b1;
        fork
            begin
                tick(120);
                stall = 1'b0;
            end
        join_none
        for (int i = 0; i < 3; i++) begin
            acc(2'b11, 1'b0, 2'b00, 14'h0100 + 14'(i), 16'($urandom), 1'b0);
            if (i == 1) check("wr_valid", {15'h0000, wval}, 16'h0001);
        end
        for (int i = 0; i < 3; i++) acc(2'b11, 1'b1, 2'b00, 14'h0100 + 14'(i), w, 1'b0);
        do_reset(1'b0);
        acc(HPP_SEL_PTR, 1'b1, 2'b00, 14'($urandom), w, 1'b0);
        // Every select code both ways, address strobe at random
        for (int s = 0; s < 4; s++) begin
            w = 16'($urandom) & ((s == 2) ? 16'h3FFF : 16'hFFFF);
            acc(s[1:0], 1'b0, 2'b00, 14'($urandom), w, 1'($urandom));
            acc(s[1:0], 1'b1, 2'b00, 14'($urandom), w, 1'($urandom));
        end
        // pointer loaded before increment run across the top address
        acc(HPP_SEL_PTR, 1'b0, 2'b00, 14'($urandom), 16'h3FFE, 1'b1);
        for (int i = 0; i < 6; i++) begin
            acc(HPP_SEL_DATA_INC, 1'b1, i[0] ? 2'b01 : 2'b10, haddr, w, i[1]);
        end
        for (int i = 0; i < 2; i++) begin
            acc(HPP_SEL_DATA_INC, 1'b0, 2'b00, haddr, 16'($urandom), 1'b0);
        end
        acc(HPP_SEL_PTR, 1'b0, 2'b01, haddr, 16'h2100, 1'b0);
        acc(HPP_SEL_PTR, 1'b1, 2'b00, haddr, w, 1'b0);
        acc(HPP_SEL_PTR, 1'b0, 2'b00, haddr, 16'h0000, 1'b1);
        acc(HPP_SEL_DATA, 1'b1, 2'b00, haddr, w, 1'b1);
        acc(HPP_SEL_DATA_INC, 1'b1, 2'b00, haddr, w, 1'b0);
        print_verdict();
    end
endmodule
